// ===== inc/timer_pkg.sv
// constants and carrier types of the compare/capture timer channel
package timer_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_IO     = 8'h04;
   localparam logic [7:0] OFF_MODE   = 8'h08;
   localparam logic [7:0] OFF_START  = 8'h0C;
   localparam logic [7:0] OFF_WREN   = 8'h10;
   localparam logic [7:0] OFF_COUNT  = 8'h14;
   localparam logic [7:0] OFF_REGB   = 8'h18;
   localparam logic [7:0] OFF_IRQEN  = 8'h1C;
   localparam logic [7:0] OFF_STATUS = 8'h20;
   localparam logic [7:0] OFF_CLEAR  = 8'h24;
   localparam logic [7:0] OFF_VEC0   = 8'h28;
   localparam logic [7:0] OFF_VEC1   = 8'h2C;
   // field codes
   localparam logic [2:0] PSC_DIV1        = 3'h0;
   localparam logic [1:0] EDGE_RISING     = 2'h0;
   localparam logic [2:0] CLR_BY_REG_B    = 3'h2;
   localparam logic [3:0] IO_TOGGLE_LOW   = 4'h3;
   localparam logic [3:0] IO_CAPTURE_BOTH = 4'hA;
   localparam logic [7:0] SRC_CC_B        = 8'h16;
   localparam logic [7:0] SRC_OVERFLOW    = 8'h19;
   localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
   localparam int          NUM_VECTORS    = 2;
   // reset values
   localparam logic [15:0] REG_B_RESET    = 16'hFFFF;
   localparam logic [15:0] COUNT_RESET    = 16'h0000;
   localparam logic [7:0]  VEC_SEL_RESET  = 8'h00;

   typedef struct packed {
      logic [2:0] prescale_select_ext;
      logic [2:0] clear_source_select;
      logic [1:0] count_edge_select;
      logic [2:0] prescale_select;
   } clock_cfg_t;

   typedef struct packed {
      logic       pin_b_output_enable;
      logic [3:0] pin_b_io_mode;
   } pin_cfg_t;

   typedef struct packed {
      logic       reg_b_buffer_mode;
      logic [3:0] channel_mode_select;
   } mode_cfg_t;

   typedef struct packed {
      logic overflow_event;
      logic capture_compare_b_event;
   } events_t;
endpackage

// ===== hdl/count_prescaler.sv
// count enable divider for the channel counter
`timescale 1ns/10ps
`default_nettype none
module count_prescaler (
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire timer_pkg::clock_cfg_t clock_cfg,
   output logic                       tick
);
   logic [7:0] div_count;

   // divide-by mask: /1, /4, /16, /64, otherwise /256
   function automatic logic [7:0] div_mask(input logic [2:0] sel, input logic [2:0] ext);
      logic [7:0] m;
      m = 8'hFF;
      if (ext == 3'h0) begin
         unique case (sel)
            3'h0: m = 8'h00;
            3'h1: m = 8'h03;
            3'h2: m = 8'h0F;
            3'h3: m = 8'h3F;
            default: m = 8'hFF;
         endcase
      end
      return m;
   endfunction

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_count <= 8'h00;
      end else begin
         div_count <= div_count + 8'h01;
      end
   end

   // with one clock every edge code counts on the pclk rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tick <= 1'b0;
      end else begin
         tick <= (div_count & div_mask(clock_cfg.prescale_select, clock_cfg.prescale_select_ext)) == 8'h00;
      end
   end

   a_full_rate_tick: assert property (@(posedge pclk) disable iff (!presetn)
      (clock_cfg.prescale_select == timer_pkg::PSC_DIV1 && clock_cfg.prescale_select_ext == 3'h0
       && clock_cfg.count_edge_select == timer_pkg::EDGE_RISING) [*2] |-> tick)
      else $error("counter enable missing at undivided rate");
endmodule
`default_nettype wire

// ===== hdl/timer_channel.sv
// one compare/capture timer channel with APB registers and interrupt routing
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - with prescale 000 and edge 00, count on every pclk rising edge.
// - compare pin output starts at the level of IO bit 2 when its pin operation is configured.
// - in compare toggle mode (0x11), counter equal to register B inverts the pin.
// - with clear source 010, a register B compare match zeroes the counter.
// - square wave continues indefinitely at 50% duty without software.
// - capture mode latches the counter into B on the selected pin edge, both edges for 1x1x.
// - capture with clear source 010 also zeroes the counter.
// - counter wrap raises overflow event, interrupt only when enabled.
// - selector 22 routes B event, selector 25 routes overflow to a vector.
module timer_channel (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        timer_pin_b_in,
   output logic             timer_pin_b_out,
   output logic             timer_pin_b_oe,
   output logic             irq,
   output logic [1:0]       vector_irq
);
   timer_pkg::clock_cfg_t clock_cfg;
   timer_pkg::pin_cfg_t   pin_cfg;
   timer_pkg::mode_cfg_t  mode_cfg;
   timer_pkg::events_t    status;
   timer_pkg::events_t    irq_enable;
   timer_pkg::events_t    events;
   timer_pkg::events_t    next_status;
   logic [15:0] channel_counter;
   logic [15:0] compare_capture_reg_b;
   logic        channel_count_start;
   logic        reg_write_enable;
   logic [7:0]  vector_source_select [timer_pkg::NUM_VECTORS];
   logic        tick;
   logic        count_tick;
   logic        pin_prev;
   logic        compare_mode;
   logic        capture_mode;
   logic        cmp_match;
   logic        capture_fire;
   logic        clear_by_b;
   logic        setup_phase;
   logic        wr_access;
   logic [31:0] read_mux;

   ////////////////////////////////////////////////////////////////////////
   // decode helpers

   function automatic logic wr_to(input logic wr, input logic [7:0] addr, input logic [7:0] off);
      return wr && (addr == off);
   endfunction

   function automatic logic is_mapped(input logic [7:0] addr);
      return (addr[1:0] == 2'h0) && (addr <= timer_pkg::OFF_VEC1);
   endfunction

   function automatic logic source_pending(input logic [7:0] sel, input timer_pkg::events_t pend);
      logic p;
      p = 1'b0;
      if (sel == timer_pkg::SRC_CC_B) begin
         p = pend.capture_compare_b_event;
      end else if (sel == timer_pkg::SRC_OVERFLOW) begin
         p = pend.overflow_event;
      end
      return p;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // APB slave: no wait state, answer registered in the setup cycle

   assign setup_phase = psel && !penable;
   assign wr_access   = psel && penable && pready && pwrite;

   always_comb begin
      read_mux = 32'h0000_0000;
      unique case (paddr)
         timer_pkg::OFF_CTRL:   read_mux[10:0] = clock_cfg;
         timer_pkg::OFF_IO:     read_mux[4:0] = pin_cfg;
         timer_pkg::OFF_MODE:   read_mux[4:0] = mode_cfg;
         timer_pkg::OFF_START:  read_mux[0] = channel_count_start;
         timer_pkg::OFF_WREN:   read_mux[0] = reg_write_enable;
         timer_pkg::OFF_COUNT:  read_mux[15:0] = channel_counter;
         timer_pkg::OFF_REGB:   read_mux[15:0] = compare_capture_reg_b;
         timer_pkg::OFF_IRQEN:  read_mux[1:0] = irq_enable;
         timer_pkg::OFF_STATUS: read_mux[1:0] = status;
         timer_pkg::OFF_VEC0:   read_mux[7:0] = vector_source_select[0];
         timer_pkg::OFF_VEC1:   read_mux[7:0] = vector_source_select[1];
         default:               read_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup_phase;
         pslverr <= setup_phase && !is_mapped(paddr);
         if (setup_phase) begin
            prdata <= read_mux;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration registers

   // the unlock bit itself is never locked, else software could not reopen it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reg_write_enable <= 1'b0;
      end else if (wr_to(wr_access, paddr, timer_pkg::OFF_WREN)) begin
         reg_write_enable <= pwdata[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_cfg <= 11'h000;
         mode_cfg  <= 5'h00;
         irq_enable <= 2'h0;
      end else if (reg_write_enable) begin
         if (wr_to(wr_access, paddr, timer_pkg::OFF_CTRL)) begin
            clock_cfg <= pwdata[10:0];
         end
         if (wr_to(wr_access, paddr, timer_pkg::OFF_MODE)) begin
            mode_cfg <= pwdata[4:0];
         end
         if (wr_to(wr_access, paddr, timer_pkg::OFF_IRQEN)) begin
            irq_enable <= pwdata[1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_cfg <= 5'h00;
      end else if (reg_write_enable && wr_to(wr_access, paddr, timer_pkg::OFF_IO)) begin
         pin_cfg <= pwdata[4:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_count_start <= 1'b0;
      end else if (wr_to(wr_access, paddr, timer_pkg::OFF_START)) begin
         channel_count_start <= pwdata[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // counter, compare and capture

   count_prescaler u_prescaler (
      .pclk      (pclk),
      .presetn   (presetn),
      .clock_cfg (clock_cfg),
      .tick      (tick)
   );

   assign count_tick   = tick && channel_count_start;
   assign compare_mode = !pin_cfg.pin_b_io_mode[3] && (pin_cfg.pin_b_io_mode[1:0] != 2'h0);
   assign capture_mode = pin_cfg.pin_b_io_mode[3];
   assign clear_by_b   = clock_cfg.clear_source_select == timer_pkg::CLR_BY_REG_B;
   assign cmp_match    = count_tick && compare_mode && (channel_counter == compare_capture_reg_b);

   // pin is synchronous; 1x00 rising, 1x01 falling, 1x1x both edges
   always_comb begin
      capture_fire = 1'b0;
      if (capture_mode && channel_count_start) begin
         if (pin_cfg.pin_b_io_mode[1]) begin
            capture_fire = timer_pin_b_in != pin_prev;
         end else if (pin_cfg.pin_b_io_mode[0]) begin
            capture_fire = pin_prev && !timer_pin_b_in;
         end else begin
            capture_fire = timer_pin_b_in && !pin_prev;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_prev <= 1'b0;
      end else begin
         pin_prev <= timer_pin_b_in;
      end
   end

   // a software write outranks counting in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         channel_counter <= timer_pkg::COUNT_RESET;
      end else if (reg_write_enable && wr_to(wr_access, paddr, timer_pkg::OFF_COUNT)) begin
         channel_counter <= pwdata[15:0];
      end else if (capture_fire && clear_by_b) begin
         channel_counter <= timer_pkg::COUNT_RESET;
      end else if (cmp_match && clear_by_b) begin
         channel_counter <= timer_pkg::COUNT_RESET;
      end else if (count_tick) begin
         channel_counter <= channel_counter + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         compare_capture_reg_b <= timer_pkg::REG_B_RESET;
      end else if (reg_write_enable && wr_to(wr_access, paddr, timer_pkg::OFF_REGB)) begin
         compare_capture_reg_b <= pwdata[15:0];
      end else if (capture_fire) begin
         compare_capture_reg_b <= channel_counter;
      end
   end

   // 0x01 low, 0x10 high, 0x11 toggle on match; bit 2 is the initial level
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_pin_b_out <= 1'b0;
      end else if (reg_write_enable && wr_to(wr_access, paddr, timer_pkg::OFF_IO)) begin
         timer_pin_b_out <= pwdata[2];
      end else if (cmp_match) begin
         unique case (pin_cfg.pin_b_io_mode[1:0])
            2'h1: timer_pin_b_out <= 1'b0;
            2'h2: timer_pin_b_out <= 1'b1;
            2'h3: timer_pin_b_out <= !timer_pin_b_out;
            default: timer_pin_b_out <= timer_pin_b_out;
         endcase
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_pin_b_oe <= 1'b0;
      end else begin
         timer_pin_b_oe <= pin_cfg.pin_b_output_enable && compare_mode;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // events, status and interrupt routing

   always_comb begin
      events.capture_compare_b_event = cmp_match || capture_fire;
      events.overflow_event = count_tick && (channel_counter == timer_pkg::COUNT_MAX)
                              && !(cmp_match && clear_by_b) && !(capture_fire && clear_by_b);
      next_status = status;
      if (wr_to(wr_access, paddr, timer_pkg::OFF_CLEAR)) begin
         next_status = status & ~pwdata[1:0];
      end
      // a new event wins over a clear in the same cycle
      next_status = next_status | events;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= 2'h0;
      end else begin
         status <= next_status;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & irq_enable);
      end
   end

   genvar v;
   generate
      for (v = 0; v < timer_pkg::NUM_VECTORS; v++) begin : g_vector
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               vector_source_select[v] <= timer_pkg::VEC_SEL_RESET;
            end else if (wr_to(wr_access, paddr, v == 0 ? timer_pkg::OFF_VEC0 : timer_pkg::OFF_VEC1)) begin
               vector_source_select[v] <= pwdata[7:0];
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               vector_irq[v] <= 1'b0;
            end else begin
               vector_irq[v] <= source_pending(vector_source_select[v], status & irq_enable);
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////
   // checks

   a_pin_init_low: assert property (@(posedge pclk) disable iff (!presetn)
      reg_write_enable && wr_to(wr_access, paddr, timer_pkg::OFF_IO)
      && pwdata[3:0] == timer_pkg::IO_TOGGLE_LOW |=> !timer_pin_b_out)
      else $error("pin did not start low");

   a_toggle_on_match: assert property (@(posedge pclk) disable iff (!presetn)
      cmp_match && pin_cfg.pin_b_io_mode == timer_pkg::IO_TOGGLE_LOW
      && !wr_to(wr_access, paddr, timer_pkg::OFF_IO) |=> timer_pin_b_out != $past(timer_pin_b_out))
      else $error("pin not inverted on match");

   a_match_clears: assert property (@(posedge pclk) disable iff (!presetn)
      cmp_match && clear_by_b && !wr_to(wr_access, paddr, timer_pkg::OFF_COUNT) |=> channel_counter == 16'h0000)
      else $error("counter not cleared on match");

   a_pin_change_cause: assert property (@(posedge pclk) disable iff (!presetn)
      timer_pin_b_out != $past(timer_pin_b_out) |-> $past(cmp_match) || $past(wr_access))
      else $error("pin changed without match");

   a_capture_value: assert property (@(posedge pclk) disable iff (!presetn)
      capture_fire && !wr_to(wr_access, paddr, timer_pkg::OFF_REGB)
      |=> compare_capture_reg_b == $past(channel_counter))
      else $error("capture value wrong");

   a_capture_clears: assert property (@(posedge pclk) disable iff (!presetn)
      capture_fire && clear_by_b && !wr_to(wr_access, paddr, timer_pkg::OFF_COUNT) |=> channel_counter == 16'h0000)
      else $error("counter not cleared on capture");

   a_overflow_irq: assert property (@(posedge pclk) disable iff (!presetn)
      events.overflow_event && irq_enable.overflow_event && !wr_access |=> status.overflow_event ##1 irq)
      else $error("overflow interrupt missing");

   a_vector_route: assert property (@(posedge pclk) disable iff (!presetn)
      events.overflow_event && irq_enable.overflow_event && !wr_access
      && vector_source_select[1] == timer_pkg::SRC_OVERFLOW ##1 !wr_access |=> vector_irq[1])
      else $error("overflow not routed to vector");

   a_stopped_frozen: assert property (@(posedge pclk) disable iff (!presetn)
      !channel_count_start && !wr_to(wr_access, paddr, timer_pkg::OFF_COUNT) |=> $stable(channel_counter))
      else $error("counter moved while stopped");

   a_locked_write: assert property (@(posedge pclk) disable iff (!presetn)
      !reg_write_enable && wr_to(wr_access, paddr, timer_pkg::OFF_CTRL) |=> $stable(clock_cfg))
      else $error("locked register changed");
endmodule
`default_nettype wire

// ===== bench/pin_partner.sv
// external pin model: resolves the two-way timer pin and drives pulses while the channel releases it
`timescale 1ns/10ps
`default_nettype none
module pin_partner (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pin_out,
   input  wire logic pin_oe,
   input  wire logic drive_level,
   output logic      pin_in
);
   logic ext_level;
   // outside driver changes only on clock edges, like a synchronous pulse source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_level <= 1'b0;
      end else begin
         ext_level <= drive_level;
      end
   end
   // channel wins the wire while its output enable is high
   assign pin_in = pin_oe ? pin_out : ext_level;
endmodule
`default_nettype wire

// ===== bench/testbench.sv
// self-checking testbench of the compare/capture timer channel
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pin_in;
   logic        pin_out;
   logic        pin_oe;
   logic        irq;
   logic [1:0]  vector_irq;
   logic        drive_level;
   logic [31:0] rd;
   logic [31:0] rd2;
   logic        err;
   int          fails;
   int          n_checks;
   int          gap;

   timer_channel u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_pin_b_in(pin_in), .timer_pin_b_out(pin_out), .timer_pin_b_oe(pin_oe),
      .irq(irq), .vector_irq(vector_irq)
   );

   pin_partner u_pin (
      .pclk(pclk), .presetn(presetn), .pin_out(pin_out), .pin_oe(pin_oe),
      .drive_level(drive_level), .pin_in(pin_in)
   );

   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // apb master: setup, access held until pready seen high at a rising edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int k;
      k = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && k < 50) begin
         @(posedge pclk);
         k++;
      end
      if (k >= 50) begin
         fails++;
         $display("Error apb answer expected 1 seen 0");
      end
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(what, exp, r);
   endtask

   task automatic cycles(input int n);
      repeat (n) @(posedge pclk);
   endtask

   initial begin
      #(20000 * 100);
      fails++;
      $display("Error watchdog expected done seen running");
      test_done();
   end

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0000_0000; drive_level = 1'b0;
      fails = 0; n_checks = 0;
      cycles(8);
      presetn <= 1'b1;
      // reset values and an unmapped place
      rd_chk("reg b reset", timer_pkg::OFF_REGB, 32'h0000_FFFF);
      rd_chk("counter reset", timer_pkg::OFF_COUNT, 32'h0000_0000);
      rd_chk("vector sel reset", timer_pkg::OFF_VEC0, 32'h0000_0000);
      apb(1'b0, 8'h30, 32'h0000_0000, rd, err);
      chk("unmapped err", 32'h1, {31'h0, err});
      chk("unmapped data", 32'h0, rd);
      // locked writes are dropped
      wr(timer_pkg::OFF_CTRL, 32'h0000_0040);
      rd_chk("locked ctrl", timer_pkg::OFF_CTRL, 32'h0000_0000);
      wr(timer_pkg::OFF_WREN, 32'h0000_0001);
      wr(timer_pkg::OFF_CTRL, 32'h0000_0000);
      wr(timer_pkg::OFF_MODE, 32'h0000_0000);
      ////////////////////////////////////////////////////////////////////////////////
      // count rate: reads three cycles apart differ by three
      wr(timer_pkg::OFF_START, 32'h0000_0001);
      apb(1'b0, timer_pkg::OFF_COUNT, 32'h0, rd, err);
      apb(1'b0, timer_pkg::OFF_COUNT, 32'h0, rd2, err);
      chk("count step", 32'h3, rd2 - rd);
      wr(timer_pkg::OFF_START, 32'h0000_0000);
      apb(1'b0, timer_pkg::OFF_COUNT, 32'h0, rd, err);
      cycles(5);
      rd_chk("frozen count", timer_pkg::OFF_COUNT, rd);
      // divide by 4: reads twelve cycles apart differ by three
      wr(timer_pkg::OFF_CTRL, 32'h0000_0001);
      wr(timer_pkg::OFF_START, 32'h0000_0001);
      apb(1'b0, timer_pkg::OFF_COUNT, 32'h0, rd, err);
      cycles(9);
      apb(1'b0, timer_pkg::OFF_COUNT, 32'h0, rd2, err);
      chk("divided step", 32'h3, rd2 - rd);
      wr(timer_pkg::OFF_START, 32'h0000_0000);
      ////////////////////////////////////////////////////////////////////////////////
      // compare toggle, clear on match, half period regB+1
      wr(timer_pkg::OFF_CTRL, 32'h0000_0040);
      wr(timer_pkg::OFF_COUNT, 32'h0000_0000);
      wr(timer_pkg::OFF_REGB, 32'h0000_0002);
      // initial level high first, so the low start below is a real change
      wr(timer_pkg::OFF_IO, 32'h0000_0014);
      wr(timer_pkg::OFF_IO, 32'h0000_0013);
      cycles(4);
      @(negedge pclk);
      chk("pin oe", 32'h1, {31'h0, pin_oe});
      chk("pin initial", 32'h0, {31'h0, pin_out});
      wr(timer_pkg::OFF_START, 32'h0000_0001);
      rd = {31'h0, pin_out};
      while (rd[0] === pin_out) @(negedge pclk);
      for (int h = 0; h < 4; h++) begin
         gap = 0;
         rd = {31'h0, pin_out};
         while (rd[0] === pin_out && gap < 100) begin
            @(negedge pclk);
            gap++;
         end
         chk("half period", 32'd3, gap);
      end
      wr(timer_pkg::OFF_START, 32'h0000_0000);
      ////////////////////////////////////////////////////////////////////////////////
      // capture on both pin edges with clear
      wr(timer_pkg::OFF_IO, 32'h0000_000A);
      wr(timer_pkg::OFF_CLEAR, 32'h0000_0003);
      wr(timer_pkg::OFF_START, 32'h0000_0001);
      cycles(4);
      drive_level <= 1'b1;
      cycles(20);
      drive_level <= 1'b0;
      cycles(6);
      rd_chk("captured width", timer_pkg::OFF_REGB, 32'd19);
      rd_chk("capture status", timer_pkg::OFF_STATUS, 32'h1);
      ////////////////////////////////////////////////////////////////////////////////
      // overflow, masking and vector routing
      wr(timer_pkg::OFF_START, 32'h0000_0000);
      // compare, drive low on match, pin released: match still raises the B event
      wr(timer_pkg::OFF_IO, 32'h0000_0001);
      wr(timer_pkg::OFF_CTRL, 32'h0000_0000);
      wr(timer_pkg::OFF_REGB, 32'h0000_FFFF);
      wr(timer_pkg::OFF_IRQEN, 32'h0000_0000);
      wr(timer_pkg::OFF_CLEAR, 32'h0000_0003);
      rd_chk("status cleared", timer_pkg::OFF_STATUS, 32'h0);
      wr(timer_pkg::OFF_COUNT, 32'h0000_FFF0);
      wr(timer_pkg::OFF_START, 32'h0000_0001);
      cycles(30);
      wr(timer_pkg::OFF_START, 32'h0000_0000);
      rd_chk("overflow status", timer_pkg::OFF_STATUS, 32'h3);
      @(negedge pclk);
      chk("masked irq", 32'h0, {31'h0, irq});
      wr(timer_pkg::OFF_VEC0, 32'd22);
      wr(timer_pkg::OFF_VEC1, 32'd25);
      wr(timer_pkg::OFF_IRQEN, 32'h0000_0003);
      cycles(2);
      @(negedge pclk);
      chk("irq on", 32'h1, {31'h0, irq});
      chk("both vectors", 32'h3, {30'h0, vector_irq});
      wr(timer_pkg::OFF_CLEAR, 32'h0000_0001);
      cycles(2);
      @(negedge pclk);
      chk("overflow vector", 32'h2, {30'h0, vector_irq});
      wr(timer_pkg::OFF_CLEAR, 32'h0000_0002);
      cycles(2);
      @(negedge pclk);
      chk("irq off", 32'h0, {31'h0, irq});
      chk("vectors off", 32'h0, {30'h0, vector_irq});
      // second wrap with interrupts already enabled
      wr(timer_pkg::OFF_COUNT, 32'h0000_FFF8);
      wr(timer_pkg::OFF_START, 32'h0000_0001);
      cycles(12);
      @(negedge pclk);
      chk("enabled overflow irq", 32'h1, {31'h0, irq});
      chk("enabled vectors", 32'h3, {30'h0, vector_irq});
      wr(timer_pkg::OFF_START, 32'h0000_0000);
      test_done();
   end
endmodule
`default_nettype wire
